// ===== stl_query_top.sv
// command interpreter for the automatic and manual self-test logs
`timescale 1ns/1ps

module stl_query_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // received characters
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic rxReady,
    // reply characters
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady,
    // completed self-test records
    input wire logic logValid,
    input wire logic logManual,
    input wire stl_pkg::stl_rec_s logRec,
    // log fill levels
    output logic [6:0] autoCount,
    output logic [6:0] manCount
);
    import stl_pkg::*;

    stl_mem_if memBus ();
    stl_log_mem uMem (.clk(clk), .rst_b(rst_b), .port(memBus));

    // ======================================================
    // state
    stl_state_e state, next_state;
    stl_kind_e kind, next_kind;
    logic manual, next_manual;
    logic dump, next_dump;
    logic [3:0][3:0] argD, next_argD;
    logic [2:0] argCnt, next_argCnt;
    logic [6:0] entry, next_entry;
    logic [3:0] field, next_field;
    logic [`STL_LINE_MAX-1:0][7:0] lineBuf, next_lineBuf;
    logic [4:0] lineLen, next_lineLen;
    logic [6:0] next_autoCount, next_manCount;
    logic [6:0] autoLast, next_autoLast, manLast, next_manLast;
    logic [6:0] argIdx, argFld, selCount;
    logic isDigit;
    stl_line_s built;

    function automatic logic [7:0] dg(input logic [3:0] d);
        return {`STL_CH_DIG_HI, d};
    endfunction : dg

    // ======================================================
    // line builder
    function automatic stl_line_s build(input stl_kind_e k, input logic man,
            input logic [3:0] f, input stl_rec_s r, input logic [6:0] last,
            input logic [6:0] cnt);
        stl_line_s ln;
        int n;
        logic [71:0] txt;
        logic [3:0] tlen;
        logic [15:0] v;
        ln = '0;
        n = 0;
        txt = '0;
        tlen = '0;
        v = '0;
        if (k == K_GAP) begin
            ln.chars[0] = `STL_CH_CR;
            ln.chars[1] = `STL_CH_CR;
            ln.len = 5'd2;
            return ln;
        end
        ln.chars[0] = `STL_CH_STAR;
        ln.chars[1] = `STL_CH_ZERO;
        ln.chars[2] = `STL_CH_LO_L;
        ln.chars[3] = man ? `STL_CH_LO_E : `STL_CH_LO_T;
        n = 4;
        if (k == K_NONE) begin
            txt = man ? `STL_TXT_NO_EVENTS : `STL_TXT_NO_TESTS;
            tlen = `STL_LEN_NO_TXT;
        end else if (k == K_COUNT) begin
            ln.chars[n] = man ? `STL_CH_UP_E : `STL_CH_UP_T; n++;
            ln.chars[n] = dg(4'(last / `STL_TEN)); n++;
            ln.chars[n] = dg(4'(last % `STL_TEN)); n++;
            ln.chars[n] = `STL_CH_SLASH; n++;
            ln.chars[n] = dg(4'(cnt / `STL_TEN)); n++;
            ln.chars[n] = dg(4'(cnt % `STL_TEN)); n++;
        end else begin
            unique case (f)
                `STL_FLD_DATE: begin
                    ln.chars[n] = dg(r.month[7:4]); n++;
                    ln.chars[n] = dg(r.month[3:0]); n++;
                    ln.chars[n] = `STL_CH_SLASH; n++;
                    ln.chars[n] = dg(r.day[7:4]); n++;
                    ln.chars[n] = dg(r.day[3:0]); n++;
                    ln.chars[n] = `STL_CH_SLASH; n++;
                    ln.chars[n] = dg(r.year[7:4]); n++;
                    ln.chars[n] = dg(r.year[3:0]); n++;
                end
                `STL_FLD_TIME: begin
                    ln.chars[n] = dg(r.hour[7:4]); n++;
                    ln.chars[n] = dg(r.hour[3:0]); n++;
                    ln.chars[n] = `STL_CH_COLON; n++;
                    ln.chars[n] = dg(r.minute[7:4]); n++;
                    ln.chars[n] = dg(r.minute[3:0]); n++;
                end
                `STL_FLD_DUR: begin
                    if (r.duration[11:8] != 4'h0) begin
                        ln.chars[n] = dg(r.duration[11:8]); n++;
                    end
                    if (r.duration[11:4] != 8'h00) begin
                        ln.chars[n] = dg(r.duration[7:4]); n++;
                    end
                    ln.chars[n] = dg(r.duration[3:0]); n++;
                    txt = `STL_TXT_MIN;
                    tlen = `STL_LEN_3;
                end
                `STL_FLD_VA, `STL_FLD_VB, `STL_FLD_VC, `STL_FLD_IA, `STL_FLD_IB,
                `STL_FLD_IC, `STL_FLD_TEMP: begin
                    if (f == `STL_FLD_TEMP) v = {4'h0, r.temp};
                    else if (f >= `STL_FLD_IA) v = r.amp[2'(f - `STL_FLD_IA)];
                    else v = r.volt[2'(f - `STL_FLD_VA)];
                    if (v[15:12] != 4'h0) begin
                        ln.chars[n] = dg(v[15:12]); n++;
                    end
                    if (v[15:8] != 8'h00) begin
                        ln.chars[n] = dg(v[11:8]); n++;
                    end
                    if (v[15:4] != 12'h000) begin
                        ln.chars[n] = dg(v[7:4]); n++;
                    end
                    ln.chars[n] = `STL_CH_DOT; n++;
                    ln.chars[n] = dg(v[3:0]); n++;
                    if (f == `STL_FLD_TEMP) begin
                        ln.chars[n] = `STL_CH_DEG; n++;
                        ln.chars[n] = `STL_CH_UP_C; n++;
                    end else begin
                        ln.chars[n] = (f >= `STL_FLD_IA) ? `STL_CH_UP_A : `STL_CH_UP_V;
                        n++;
                        ln.chars[n] = `STL_CH_SPACE; n++;
                        ln.chars[n] = `STL_CH_UP_A + 8'((f - `STL_FLD_VA) % 4'd3); n++;
                    end
                end
                `STL_FLD_ALARM: begin
                    for (int i = 0; i < 8; i++) begin
                        ln.chars[n] = 8'(`STL_TXT_ALARMS >> ((7 - i) * 8)); n++;
                    end
                    txt = r.alarm ? `STL_TXT_YES : `STL_TXT_NO;
                    tlen = r.alarm ? `STL_LEN_3 : `STL_LEN_2;
                end
                `STL_FLD_TRIG: begin
                    txt = r.yearly ? `STL_TXT_YEARLY : `STL_TXT_MONTHLY;
                    tlen = r.yearly ? `STL_LEN_YEARLY : `STL_LEN_MONTHLY;
                end
                default: begin
                end
            endcase
        end
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < tlen) begin
                ln.chars[n] = 8'(txt >> ((int'(tlen) - 1 - i) * 8)); n++;
            end
        end
        ln.chars[n] = `STL_CH_X; n++;
        ln.chars[n] = `STL_CH_CR; n++;
        ln.len = 5'(n);
        return ln;
    endfunction : build

    // ======================================================
    // decode helpers
    assign isDigit = (rxData >= `STL_CH_ZERO) && (rxData <= `STL_CH_NINE);
    assign argIdx = 7'({3'h0, argD[3]} * `STL_TEN) + {3'h0, argD[2]};
    assign argFld = 7'({3'h0, argD[1]} * `STL_TEN) + {3'h0, argD[0]};
    assign selCount = manual ? manCount : autoCount;
    assign built = build(kind, manual, field, memBus.rdData,
                         manual ? manLast : autoLast, selCount);
    assign rxReady = (state == S_STAR) || (state == S_UNIT) || (state == S_CMD1)
                     || (state == S_CMD2) || (state == S_ARG);
    assign txValid = (state == S_SEND);
    assign txData = lineBuf[0];
    assign memBus.rdEn = (state == S_READ);
    assign memBus.rdAddr = (manual ? `STL_MAN_BASE : 8'h00) + {1'b0, entry} - 8'h01;
    assign memBus.wrData = logRec;

    // ======================================================
    // appending completed self-tests
    always_comb begin
        next_autoCount = autoCount;
        next_manCount = manCount;
        memBus.wrEn = 1'b0;
        memBus.wrAddr = {1'b0, autoCount};
        if (logValid && logManual && manCount < `STL_MAX_ENTRIES) begin
            memBus.wrEn = 1'b1;
            memBus.wrAddr = `STL_MAN_BASE + {1'b0, manCount};
            next_manCount = manCount + 7'h01;
        end else if (logValid && !logManual && autoCount < `STL_MAX_ENTRIES) begin
            memBus.wrEn = 1'b1;
            next_autoCount = autoCount + 7'h01;
        end
    end

    // ======================================================
    // command parse and reply sequencing
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_manual = manual;
        next_dump = dump;
        next_argD = argD;
        next_argCnt = argCnt;
        next_entry = entry;
        next_field = field;
        next_lineBuf = lineBuf;
        next_lineLen = lineLen;
        next_autoLast = autoLast;
        next_manLast = manLast;
        unique case (state)
            S_STAR: if (rxValid && rxData == `STL_CH_STAR) begin
                next_state = S_UNIT;
                next_argCnt = 3'h0;
            end
            S_UNIT: if (rxValid) begin
                next_state = (rxData == `STL_CH_ZERO) ? S_CMD1 : S_STAR;
            end
            S_CMD1: if (rxValid) begin
                next_dump = (rxData == `STL_CH_UP_D);
                next_state = (rxData == `STL_CH_UP_D || rxData == `STL_CH_UP_L)
                             ? S_CMD2 : S_STAR;
            end
            S_CMD2: if (rxValid) begin
                next_manual = (rxData == `STL_CH_UP_E);
                next_state = (rxData == `STL_CH_UP_T || (!dump && rxData == `STL_CH_UP_E))
                             ? S_ARG : S_STAR;
            end
            S_ARG: if (rxValid) begin
                next_state = S_STAR;
                if (isDigit && argCnt < `STL_ARG_DIGITS) begin
                    next_argD = {argD[2:0], rxData[3:0]};
                    next_argCnt = argCnt + 3'h1;
                    next_state = S_ARG;
                end else if (rxData == `STL_CH_CR && dump) begin
                    if (argCnt == 3'h1 && argD[0] == 4'h0 && autoCount != 7'h00) begin
                        next_entry = 7'h01;
                        next_field = `STL_FLD_DATE;
                        next_kind = K_FIELD;
                        next_state = S_READ;
                    end
                end else if (rxData == `STL_CH_CR && argCnt == `STL_ARG_DIGITS) begin
                    if (argD == `STL_ARG_COUNT) begin
                        next_kind = (selCount == 7'h00) ? K_NONE : K_COUNT;
                        next_state = S_LOAD;
                    end else if (argIdx != 7'h00 && argIdx <= selCount
                            && argFld <= (manual ? 7'(`STL_MAN_LAST_FLD)
                                                 : 7'(`STL_AUTO_LAST_FLD))) begin
                        next_entry = argIdx;
                        next_field = argFld[3:0];
                        next_kind = K_FIELD;
                        next_state = S_READ;
                        if (manual) next_manLast = argIdx;
                        else next_autoLast = argIdx;
                    end
                end
            end
            S_READ: next_state = S_LOAD;
            S_LOAD: begin
                next_lineBuf = built.chars;
                next_lineLen = built.len;
                next_state = S_SEND;
            end
            S_SEND: if (txReady) begin
                next_lineBuf = lineBuf >> 8;
                next_lineLen = lineLen - 5'h01;
                if (lineLen == 5'h01) begin
                    next_state = S_STAR;
                    if (dump && kind == K_GAP) begin
                        next_entry = entry + 7'h01;
                        next_field = `STL_FLD_DATE;
                        next_kind = K_FIELD;
                        next_state = S_READ;
                    end else if (dump && kind == K_FIELD) begin
                        if (field < `STL_AUTO_LAST_FLD) begin
                            next_field = field + 4'h1;
                            next_state = S_READ;
                        end else if (entry < autoCount) begin
                            next_kind = K_GAP;
                            next_state = S_LOAD;
                        end
                    end
                end
            end
            default: next_state = S_STAR;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_STAR;
            kind <= K_FIELD;
            manual <= 1'b0;
            dump <= 1'b0;
            argD <= '0;
            argCnt <= '0;
            entry <= '0;
            field <= '0;
            lineBuf <= '0;
            lineLen <= '0;
            autoCount <= '0;
            manCount <= '0;
            autoLast <= '0;
            manLast <= '0;
        end else begin
            state <= next_state;
            kind <= next_kind;
            manual <= next_manual;
            dump <= next_dump;
            argD <= next_argD;
            argCnt <= next_argCnt;
            entry <= next_entry;
            field <= next_field;
            lineBuf <= next_lineBuf;
            lineLen <= next_lineLen;
            autoCount <= next_autoCount;
            manCount <= next_manCount;
            autoLast <= next_autoLast;
            manLast <= next_manLast;
        end
    end

    // ======================================================
    // checks
    a_auto_append: assert property (@(posedge clk) disable iff (!rst_b)
        logValid && !logManual && autoCount < `STL_MAX_ENTRIES
        |=> autoCount == $past(autoCount) + 7'h01) else $error("automatic record lost");
    a_man_append: assert property (@(posedge clk) disable iff (!rst_b)
        logValid && logManual && manCount < `STL_MAX_ENTRIES
        |=> manCount == $past(manCount) + 7'h01) else $error("manual record lost");
    a_count_limit: assert property (@(posedge clk) disable iff (!rst_b)
        autoCount <= `STL_MAX_ENTRIES && manCount <= `STL_MAX_ENTRIES)
        else $error("log count above limit");
    a_field_range: assert property (@(posedge clk) disable iff (!rst_b)
        state == S_READ |-> field <= (manual ? `STL_MAN_LAST_FLD : `STL_AUTO_LAST_FLD)
        && entry != 7'h00 && entry <= selCount) else $error("read outside log");
    a_line_start: assert property (@(posedge clk) disable iff (!rst_b)
        state == S_LOAD && kind != K_GAP |=> txValid && txData == `STL_CH_STAR)
        else $error("reply not opened by star");
    a_line_end: assert property (@(posedge clk) disable iff (!rst_b)
        txValid && lineLen == 5'h02 && kind != K_GAP
        |-> txData == `STL_CH_X && lineBuf[1] == `STL_CH_CR) else $error("bad terminator");
    a_none_text: assert property (@(posedge clk) disable iff (!rst_b)
        state == S_LOAD && kind == K_NONE |=> lineBuf[4] == 8'h4e && selCount == 7'h00)
        else $error("no-records text wrong");
    a_gap_lines: assert property (@(posedge clk) disable iff (!rst_b)
        state == S_LOAD && kind == K_GAP
        |=> lineLen == 5'h02 && lineBuf[0] == `STL_CH_CR && lineBuf[1] == `STL_CH_CR)
        else $error("record gap wrong");
    a_dump_next: assert property (@(posedge clk) disable iff (!rst_b)
        txValid && txReady && lineLen == 5'h01 && dump && kind == K_FIELD
        && field < `STL_AUTO_LAST_FLD |=> state == S_READ ##2 state == S_SEND)
        else $error("dump skipped a field");
    c_count_reply: cover property (@(posedge clk) state == S_LOAD && kind == K_COUNT);
    c_field_reply: cover property (@(posedge clk) state == S_LOAD && !dump && kind == K_FIELD);
    c_dump_gap: cover property (@(posedge clk) state == S_LOAD && kind == K_GAP);
    c_log_full: cover property (@(posedge clk) autoCount == `STL_MAX_ENTRIES);
endmodule : stl_query_top

// ===== stl_map.svh
// constants of the self-test log query interpreter
// Contract
// - log a record after every automatic self-test (code drops the record once 75 are stored)
// - automatic record has twelve fields, 00 to 11
// - field 00 date mm/dd/yy, 01 time hh:mm
// - field 02 duration in minutes plus Min
// - fields 03-05 phase voltages, one decimal, phase tagged
// - fields 06-08 phase currents, one decimal, phase tagged
// - field 09 ambient temperature, one decimal, Celsius
// - field 10 alarm status, one of two texts
// - field 11 monthly or yearly trigger text
// - dump streams every field of every record (code dumps the automatic log only)
// - two empty lines between dumped records
// - manual count query 9100, empty gives no-records text
// - manual count reply last/total, total at most 75
// - log eleven-field record per manual self-test (code drops the record once 75 are stored)
// - manual fields as automatic, trigger field omitted
// - automatic count query: no-tests text or last/total
`ifndef STL_MAP_SVH
`define STL_MAP_SVH

// ==========================================================
// log geometry
`define STL_MAX_ENTRIES 7'd75
`define STL_MAN_BASE 8'd75
`define STL_MEM_DEPTH 150
`define STL_LINE_MAX 20
`define STL_AUTO_LAST_FLD 4'd11
`define STL_MAN_LAST_FLD 4'd10
`define STL_ARG_COUNT 16'h9100
`define STL_ARG_DIGITS 3'd4
`define STL_TEN 7'd10

// ==========================================================
// field numbers
`define STL_FLD_DATE 4'd0
`define STL_FLD_TIME 4'd1
`define STL_FLD_DUR 4'd2
`define STL_FLD_VA 4'd3
`define STL_FLD_VB 4'd4
`define STL_FLD_VC 4'd5
`define STL_FLD_IA 4'd6
`define STL_FLD_IB 4'd7
`define STL_FLD_IC 4'd8
`define STL_FLD_TEMP 4'd9
`define STL_FLD_ALARM 4'd10
`define STL_FLD_TRIG 4'd11

// ==========================================================
// characters
`define STL_CH_STAR 8'h2a
`define STL_CH_ZERO 8'h30
`define STL_CH_NINE 8'h39
`define STL_CH_DIG_HI 4'h3
`define STL_CH_CR 8'h0d
`define STL_CH_SLASH 8'h2f
`define STL_CH_COLON 8'h3a
`define STL_CH_DOT 8'h2e
`define STL_CH_SPACE 8'h20
`define STL_CH_X 8'h58
`define STL_CH_LO_L 8'h6c
`define STL_CH_LO_T 8'h74
`define STL_CH_LO_E 8'h65
`define STL_CH_UP_L 8'h4c
`define STL_CH_UP_T 8'h54
`define STL_CH_UP_E 8'h45
`define STL_CH_UP_D 8'h44
`define STL_CH_UP_V 8'h56
`define STL_CH_UP_A 8'h41
`define STL_CH_UP_C 8'h43
`define STL_CH_DEG 8'hb0

// ==========================================================
// fixed texts, right aligned in 72 bits
`define STL_TXT_ALARMS 72'h416c61726d733a20
`define STL_LEN_ALARMS 4'd8
`define STL_TXT_YES 72'h596573
`define STL_TXT_MIN 72'h4d696e
`define STL_LEN_3 4'd3
`define STL_TXT_NO 72'h4e6f
`define STL_LEN_2 4'd2
`define STL_TXT_MONTHLY 72'h4d6f6e74686c79
`define STL_LEN_MONTHLY 4'd7
`define STL_TXT_YEARLY 72'h596561726c79
`define STL_LEN_YEARLY 4'd6
`define STL_TXT_NO_TESTS 72'h4e6f20546573747320
`define STL_TXT_NO_EVENTS 72'h4e6f204576656e7473
`define STL_LEN_NO_TXT 4'd9

`endif

// ===== stl_pkg.sv
// types of the self-test log query interpreter
`include "stl_map.svh"

package stl_pkg;
    // record as stored, numeric values in bcd digits, alarm and yearly as single-bit flags
    typedef struct packed {
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] year;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [11:0] duration;
        logic [2:0][15:0] volt;
        logic [2:0][15:0] amp;
        logic [11:0] temp;
        logic alarm;
        logic yearly;
    } stl_rec_s;

    typedef struct packed {
        logic [`STL_LINE_MAX-1:0][7:0] chars;
        logic [4:0] len;
    } stl_line_s;

    typedef enum logic [3:0] {
        S_STAR, S_UNIT, S_CMD1, S_CMD2, S_ARG, S_READ, S_LOAD, S_SEND
    } stl_state_e;

    typedef enum logic [1:0] {K_FIELD, K_NONE, K_COUNT, K_GAP} stl_kind_e;
endpackage : stl_pkg

// ===== stl_mem_if.sv
// record memory port between controller and store
`timescale 1ns/1ps

interface stl_mem_if;
    import stl_pkg::*;
    logic wrEn;
    logic [7:0] wrAddr;
    stl_rec_s wrData;
    logic rdEn;
    logic [7:0] rdAddr;
    stl_rec_s rdData;
    modport ctrl (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
    modport mem (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface : stl_mem_if

// ===== stl_log_mem.sv
// record store for both logs, registered read
`timescale 1ns/1ps

module stl_log_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // port
    stl_mem_if.mem port
);
    import stl_pkg::*;

    stl_rec_s store [0:`STL_MEM_DEPTH-1];
    stl_rec_s next_rdData;

    always_comb begin
        next_rdData = port.rdData;
        if (port.rdEn) begin
            next_rdData = store[port.rdAddr];
        end
    end

    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port.rdData <= '0;
        end else begin
            port.rdData <= next_rdData;
        end
    end
endmodule : stl_log_mem

// ===== stl_host_model.sv
// host terminal model taking reply characters, prompt or stalling
`timescale 1ns/1ps

module stl_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // reply handshake
    output logic txReady,
    // pace select
    input wire logic slow
);
    int seed = 47144;

    // stalls at random while slow, always during reset
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            txReady <= 1'b0;
        else
            txReady <= !slow || ($random(seed) % 3 == 0);
    end
endmodule : stl_host_model

// ===== stl_query_top_tb_top.sv
// self-checking testbench of the self-test log query interpreter
`timescale 1ns/1ps

module stl_query_top_tb_top;
    import stl_pkg::*;
    logic clk, rst_b, rxValid, rxReady, txValid, txReady, logValid, logManual, slow;
    logic [7:0] rxData, txData;
    logic [6:0] autoCount, manCount;
    stl_rec_s logRec;
    stl_rec_s recs[2];
    logic [7:0] exp[$];
    int n_errors = 0, n_tests = 0, seed = 47144, cyc = 0;
    bit hung = 1'b0;

    stl_query_top stl_query_top_i (.clk(clk), .rst_b(rst_b), .rxValid(rxValid),
        .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData),
        .txReady(txReady), .logValid(logValid), .logManual(logManual), .logRec(logRec),
        .autoCount(autoCount), .manCount(manCount));
    stl_host_model stl_host_model_i (.clk(clk), .rst_b(rst_b), .txReady(txReady), .slow(slow));

    // ==========================================================
    // helpers
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk(logic [7:0] got, logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk

    task automatic line(string p, string body);
        string s;
        s = {"*0", p, body, "X\r"};
        foreach (s[i]) exp.push_back(s[i]);
    endtask : line

    task automatic send(string s);
        foreach (s[i]) begin
            rxValid <= 1'b1;
            rxData <= s[i];
            do @(posedge clk); while (!rxReady);
        end
        rxValid <= 1'b0;
        rxData <= ~rxData;
        @(posedge clk);
    endtask : send

    task automatic finish_test(string name);
        int n;
        n = 0;
        while ((exp.size() != 0 || !rxReady) && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n == 4000)
            hung = 1'b1;
        repeat (20) @(posedge clk);
        $display("test %s done", name);
    endtask : finish_test

    task automatic add(logic man, stl_rec_s r);
        logValid <= 1'b1;
        logManual <= man;
        logRec <= r;
        @(posedge clk);
        logValid <= 1'b0;
        @(posedge clk);
    endtask : add

    function automatic logic [3:0] dg();
        return 4'($unsigned($random(seed)) % 10);
    endfunction : dg

    function automatic stl_rec_s mk(logic a, logic y);
        stl_rec_s r;
        r.month = {dg(), dg()};
        r.day = {dg(), dg()};
        r.year = {dg(), dg()};
        r.hour = {dg(), dg()};
        r.minute = {dg(), dg()};
        r.duration = {4'h0, dg(), 4'h1 | dg()};
        for (int i = 0; i < 3; i++) begin
            r.volt[i] = {dg(), dg(), dg(), dg()};
            r.amp[i] = {4'h0, dg(), dg(), dg()};
        end
        r.temp = {4'h1 | dg(), dg(), dg()};
        r.alarm = a;
        r.yearly = y;
        return r;
    endfunction : mk

    function automatic string ip(logic [15:0] v);
        if (v[15:4] == 12'h000)
            return $sformatf(".%h", v[3:0]);
        return $sformatf("%0h.%h", v[15:4], v[3:0]);
    endfunction : ip

    function automatic string fld(stl_rec_s r, int f);
        string ph;
        ph = (f % 3 == 0) ? "A" : (f % 3 == 1) ? "B" : "C";
        case (f)
            0: return $sformatf("%h/%h/%h", r.month, r.day, r.year);
            1: return $sformatf("%h:%h", r.hour, r.minute);
            2: return $sformatf("%0hMin", r.duration);
            3, 4, 5: return {ip(r.volt[f-3]), "V ", ph};
            6, 7, 8: return {ip(r.amp[f-6]), "A ", ph};
            9: return $sformatf("%h.%h%cC", r.temp[11:4], r.temp[3:0], 8'hb0);
            10: return r.alarm ? "Alarms: Yes" : "Alarms: No";
            default: return r.yearly ? "Yearly" : "Monthly";
        endcase
    endfunction : fld

    // ==========================================================
    // clock, reply watcher, timeout
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rst_b === 1'b1 && txValid === 1'b1 && txReady === 1'b1) begin
            if (exp.size() == 0)
                chk(txData, 8'hff);
            else
                chk(txData, exp.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000 || hung) begin
            n_errors++;
            final_report();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        rxValid = 1'b0;
        rxData = 8'h00;
        logValid = 1'b0;
        logManual = 1'b0;
        logRec = '0;
        slow = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        line("lt", "No Tests ");
        send("*0LT9100\r");
        line("le", "No Events");
        send("*0LE9100\r");
        finish_test("empty");
        recs[0] = mk(1'b0, 1'b1);
        recs[1] = mk(1'b1, 1'b0);
        add(1'b0, recs[0]);
        add(1'b0, recs[1]);
        add(1'b1, recs[1]);
        @(posedge clk);
        #1;
        chk({1'b0, autoCount}, 8'h02);
        chk({1'b0, manCount}, 8'h01);
        for (int f = 0; f < 12; f++) begin
            slow <= f[0];
            line("lt", fld(recs[1], f));
            send($sformatf("*0LT02%02d\r", f));
        end
        finish_test("auto fields");
        for (int f = 0; f < 11; f++) begin
            line("le", fld(recs[1], f));
            send($sformatf("*0LE01%02d\r", f));
        end
        send("*0LE0111\r");
        send("*0LT0300\r");
        send("*0LT0000\r");
        finish_test("manual fields");
        line("lt", "T02/02");
        send("*0LT9100\r");
        line("le", "E01/01");
        send("*0LE9100\r");
        finish_test("counts");
        slow <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            if (r == 1) begin
                exp.push_back(8'h0d);
                exp.push_back(8'h0d);
            end
            for (int f = 0; f < 12; f++)
                line("lt", fld(recs[r], f));
        end
        send("*0DT0\r");
        finish_test("dump");
        // fill the automatic log past its limit, extra record dropped
        for (int i = 0; i < 74; i++)
            add(1'b0, mk(1'b0, 1'b0));
        #1;
        chk({1'b0, autoCount}, 8'h4b);
        line("lt", "T02/75");
        send("*0LT9100\r");
        finish_test("full");
        final_report();
    end
endmodule : stl_query_top_tb_top
